// ===== common/bfacs_pkg.sv
// Shared constants, types and register layout of the boot flash alias and
// configuration loader.
// Assumes a single system clock domain and a flash read port with ECC status.
package bfacs_pkg;

  // Data path widths
  localparam int WORD_W = 32;
  localparam int TAG_W = 16;
  localparam int CFG_WORDS = 6;
  localparam int IDX_W = 3;
  localparam int IRQ_W = 3;

  // Layout of a bank sequence word
  localparam int TAG_LSB = 0;
  localparam int CHK_LSB = 16;

  // Layout of the reset control register
  localparam int SWAP_BIT = 0;
  localparam int DONE_BIT = 1;
  localparam int FAIL_BIT = 26;
  localparam int ERR_BIT = 27;

  // Interrupt status and mask layout
  localparam int IRQ_ERR = 0;
  localparam int IRQ_FAIL = 1;
  localparam int IRQ_DONE = 2;

  // Register byte offsets
  localparam logic [5:0] OFF_RESET_CONTROL = 6'h00;
  localparam logic [5:0] OFF_IRQ_STATUS = 6'h04;
  localparam logic [5:0] OFF_IRQ_MASK = 6'h08;
  localparam logic [5:0] OFF_SEQ_TAGS = 6'h0C;
  localparam logic [5:0] OFF_CFG_BASE = 6'h10;

  // Reset and default values
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic [TAG_W-1:0] DEFAULT_TAG = 16'h0000;
  localparam logic [WORD_W-1:0] CFG_DEFAULT = 32'hFFFFFFFF;
  localparam logic [WORD_W-1:0] READ_ZERO = 32'h00000000;

  // Word slots of the configuration space, in load order
  localparam logic [IDX_W-1:0] IDX_SIGNATURE = 3'h0;
  localparam logic [IDX_W-1:0] IDX_CODE_PROTECT = 3'h1;
  localparam logic [IDX_W-1:0] IDX_LAST = 3'h5;

  // Bank and space selectors on the flash port
  localparam logic BANK1 = 1'b0;
  localparam logic BANK2 = 1'b1;
  localparam logic SPACE_SEQ = 1'b0;
  localparam logic SPACE_CFG = 1'b1;

  typedef enum logic [1:0] {
    BFACS_ST_SEQ = 2'b00,
    BFACS_ST_CFG = 2'b01,
    BFACS_ST_DONE = 2'b11
  } bfacs_state_e;

  typedef struct packed {
    logic valid;
    logic bank;
    logic alt;
    logic space;
    logic [IDX_W-1:0] index;
  } bfacs_req_s;

  typedef struct packed {
    logic valid;
    logic ue;
    logic [WORD_W-1:0] data;
  } bfacs_rsp_s;

endpackage

// ===== logic/bfacs_seq_check.sv
// Validation of one sequence word: tag against its complement check field.
// Purely combinational; fed by the flash read data on the same clock.
`timescale 1ns/1ps
module bfacs_seq_check (
  input wire logic [bfacs_pkg::WORD_W-1:0] word_i, // Sequence word as read
  output logic [bfacs_pkg::TAG_W-1:0] sequence_tag_o, // Tag field
  output logic tag_valid_o // Check field is the complement of the tag
);

  logic [bfacs_pkg::TAG_W-1:0] sequence_check;

  assign sequence_tag_o = word_i[bfacs_pkg::TAG_LSB +: bfacs_pkg::TAG_W];
  assign sequence_check = word_i[bfacs_pkg::CHK_LSB +: bfacs_pkg::TAG_W];
  assign tag_valid_o = (sequence_check == ~sequence_tag_o);

endmodule

// ===== logic/bfacs_irq_regs.sv
// Sticky interrupt status, mask and level interrupt output.
// Assumes events are one-cycle pulses and clears come from a status read.
`timescale 1ns/1ps
module bfacs_irq_regs (
  input wire logic sys_clk_i, // System clock
  input wire logic reset_n_i, // Synchronous reset, active low
  input wire logic ce_i, // Clock enable
  input wire logic [bfacs_pkg::IRQ_W-1:0] event_i, // Event pulses
  input wire logic [bfacs_pkg::IRQ_W-1:0] clear_i, // Bits cleared by a read
  input wire logic mask_wr_i, // Mask write strobe
  input wire logic [bfacs_pkg::IRQ_W-1:0] mask_data_i, // New mask value
  output logic [bfacs_pkg::IRQ_W-1:0] status_o, // Sticky status
  output logic [bfacs_pkg::IRQ_W-1:0] mask_o, // Mask
  output logic irq_o // Level interrupt
);

  logic [bfacs_pkg::IRQ_W-1:0] next_status;

  // A new event wins over a clear in the same cycle
  assign next_status = (status_o & ~clear_i) | event_i;

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      status_o <= '0;
    end else if (ce_i) begin
      status_o <= next_status;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      mask_o <= bfacs_pkg::IRQ_MASK_RST;
    end else if (ce_i && mask_wr_i) begin
      mask_o <= mask_data_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(next_status & (mask_wr_i ? mask_data_i : mask_o));
    end
  end

endmodule

// ===== logic/bfacs_top.sv
// Boot flash alias selection and configuration word loader.
// Assumes a flash read port that answers each held request with one
// valid pulse carrying data and an uncorrectable-ECC flag.
//
// Notes on behaviour
// - Bank1 tag greater or equal: bank1 lower
// - Bank2 tag strictly greater: swap the banks
// - Tag valid only if check is complement
// - Invalid tag: use alternate sequence word
// - Configuration words come from lower alias bank
// - Every sequence and configuration word has alternate
// - Primary ECC error: set error flag, use alternate
// - Both copies unusable: default; failure flag only if both had ECC errors
`timescale 1ns/1ps
module bfacs_top (
  input wire logic sys_clk_i, // System clock, 20 MHz
  input wire logic reset_n_i, // Synchronous reset, active low
  input wire logic ce_i, // Clock enable, freezes state when low
  output bfacs_pkg::bfacs_req_s flash_req_o, // Flash read request
  input wire bfacs_pkg::bfacs_rsp_s flash_rsp_i, // Flash read answer
  input wire logic [5:0] avs_address_i, // Avalon byte address
  input wire logic avs_read_i, // Avalon read
  input wire logic avs_write_i, // Avalon write
  input wire logic [31:0] avs_writedata_i, // Avalon write data
  input wire logic [3:0] avs_byteenable_i, // Avalon byte enables
  output logic [31:0] avs_readdata_o, // Avalon read data
  output logic avs_waitrequest_o, // Avalon wait request
  output logic irq_o, // Level interrupt
  output logic lower_bank_o, // Bank mapped to the lower alias region
  output logic [bfacs_pkg::CFG_WORDS-1:0][bfacs_pkg::WORD_W-1:0] device_config_words_o, // Loaded words
  output logic boot_config_error_flag_o, // Primary word ECC error seen
  output logic boot_config_failure_flag_o, // ECC error in both copies
  output logic boot_done_o // Start-up complete, releases the device
);

  bfacs_pkg::bfacs_state_e state;
  logic bank_q;
  logic alt_q;
  logic prim_ue_q;
  logic [bfacs_pkg::IDX_W-1:0] idx_q;
  logic [bfacs_pkg::TAG_W-1:0] tag1_q;
  logic [bfacs_pkg::TAG_W-1:0] tag2_q;

  logic take;
  logic seq_ok;
  logic [bfacs_pkg::TAG_W-1:0] seq_tag;
  logic [bfacs_pkg::TAG_W-1:0] new_tag;
  logic in_seq;
  logic in_cfg;
  logic prim_bad;
  logic use_default;
  logic word_done;
  logic cfg_store;
  logic ev_err;
  logic ev_fail;
  logic ev_done;

  bfacs_seq_check u_seq_check (
    .word_i(flash_rsp_i.data),
    .sequence_tag_o(seq_tag),
    .tag_valid_o(seq_ok)
  );

  assign take = flash_req_o.valid & flash_rsp_i.valid;
  assign in_seq = (state == bfacs_pkg::BFACS_ST_SEQ);
  assign in_cfg = (state == bfacs_pkg::BFACS_ST_CFG);

  // Primary copy unusable: ECC failure, or a sequence tag failing its check
  assign prim_bad = take & ~alt_q & (flash_rsp_i.ue | (in_seq & ~seq_ok));
  // Alternate copy unusable as well: fall back to the default value
  assign use_default = alt_q & (flash_rsp_i.ue | (in_seq & ~seq_ok));
  assign word_done = take & ~prim_bad;
  assign cfg_store = word_done & in_cfg;
  assign new_tag = use_default ? bfacs_pkg::DEFAULT_TAG : seq_tag;

  assign ev_err = take & ~alt_q & flash_rsp_i.ue;
  assign ev_fail = take & alt_q & flash_rsp_i.ue & prim_ue_q;
  assign ev_done = cfg_store & (idx_q == bfacs_pkg::IDX_LAST);

  // Start-up sequencer
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      state <= bfacs_pkg::BFACS_ST_SEQ;
      bank_q <= bfacs_pkg::BANK1;
      alt_q <= 1'b0;
      prim_ue_q <= 1'b0;
      idx_q <= bfacs_pkg::IDX_SIGNATURE;
    end else if (ce_i && take) begin
      if (prim_bad) begin
        alt_q <= 1'b1;
        prim_ue_q <= flash_rsp_i.ue;
      end else begin
        alt_q <= 1'b0;
        prim_ue_q <= 1'b0;
        case (state)
          bfacs_pkg::BFACS_ST_SEQ: begin
            if (bank_q == bfacs_pkg::BANK2) begin
              state <= bfacs_pkg::BFACS_ST_CFG;
              idx_q <= bfacs_pkg::IDX_SIGNATURE;
            end else begin
              bank_q <= bfacs_pkg::BANK2;
            end
          end
          bfacs_pkg::BFACS_ST_CFG: begin
            if (idx_q == bfacs_pkg::IDX_LAST) begin
              state <= bfacs_pkg::BFACS_ST_DONE;
            end else begin
              idx_q <= idx_q + 3'h1;
            end
          end
          default: begin
            state <= bfacs_pkg::BFACS_ST_DONE;
          end
        endcase
      end
    end
  end

  // Sequence tags of both banks
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      tag1_q <= bfacs_pkg::DEFAULT_TAG;
      tag2_q <= bfacs_pkg::DEFAULT_TAG;
    end else if (ce_i && word_done && in_seq) begin
      if (bank_q == bfacs_pkg::BANK1) begin
        tag1_q <= new_tag;
      end else begin
        tag2_q <= new_tag;
      end
    end
  end

  // Alias mapping, resolved when the second tag arrives
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      lower_bank_o <= bfacs_pkg::BANK1;
    end else if (ce_i && word_done && in_seq && bank_q == bfacs_pkg::BANK2) begin
      if (new_tag > tag1_q) begin
        lower_bank_o <= bfacs_pkg::BANK2;
      end else begin
        lower_bank_o <= bfacs_pkg::BANK1;
      end
    end
  end

  // Flash request: held until answered, one idle cycle between requests
  // The idle cycle lets alt_q, idx_q and the mapping settle before the next read
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      flash_req_o <= '0;
    end else if (ce_i) begin
      if (flash_req_o.valid) begin
        if (flash_rsp_i.valid) begin
          flash_req_o.valid <= 1'b0;
        end
      end else if (state != bfacs_pkg::BFACS_ST_DONE) begin
        flash_req_o.valid <= 1'b1;
        flash_req_o.alt <= alt_q;
        flash_req_o.index <= in_cfg ? idx_q : bfacs_pkg::IDX_SIGNATURE;
        if (in_cfg) begin
          flash_req_o.space <= bfacs_pkg::SPACE_CFG;
          flash_req_o.bank <= lower_bank_o;
        end else begin
          flash_req_o.space <= bfacs_pkg::SPACE_SEQ;
          flash_req_o.bank <= bank_q;
        end
      end
    end
  end

  // Configuration word storage, one slot per word
  genvar gi;
  generate
    for (gi = 0; gi < bfacs_pkg::CFG_WORDS; gi++) begin : g_cfg
      always_ff @(posedge sys_clk_i) begin
        if (!reset_n_i) begin
          device_config_words_o[gi] <= bfacs_pkg::CFG_DEFAULT;
        end else if (ce_i && cfg_store && idx_q == bfacs_pkg::IDX_W'(gi)) begin
          if (use_default) begin
            device_config_words_o[gi] <= bfacs_pkg::CFG_DEFAULT;
          end else begin
            device_config_words_o[gi] <= flash_rsp_i.data;
          end
        end
      end
    end
  endgenerate

  // Boot status flags
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      boot_config_error_flag_o <= 1'b0;
      boot_config_failure_flag_o <= 1'b0;
    end else if (ce_i) begin
      if (ev_err) begin
        boot_config_error_flag_o <= 1'b1;
      end
      if (ev_fail) begin
        boot_config_failure_flag_o <= 1'b1;
      end
    end
  end

  // Release only after every word is loaded; words, tags, mapping and boot flags hold afterwards
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      boot_done_o <= 1'b0;
    end else if (ce_i && ev_done) begin
      boot_done_o <= 1'b1;
    end
  end

  // Avalon-MM slave
  logic [bfacs_pkg::IRQ_W-1:0] irq_status;
  logic [bfacs_pkg::IRQ_W-1:0] irq_mask;
  logic [bfacs_pkg::IRQ_W-1:0] irq_clear;
  logic [31:0] rd_mux;
  logic [3:0] cfg_sel;
  logic acc_done;
  logic mask_wr;

  assign acc_done = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
  assign mask_wr = avs_write_i & acc_done & (avs_address_i == bfacs_pkg::OFF_IRQ_MASK)
    & avs_byteenable_i[0];
  assign cfg_sel = avs_address_i[5:2] - bfacs_pkg::OFF_CFG_BASE[5:2];

  // Clear exactly the status bits that the completed read returned
  always_comb begin
    irq_clear = '0;
    if (avs_read_i && acc_done && avs_address_i == bfacs_pkg::OFF_IRQ_STATUS) begin
      irq_clear = avs_readdata_o[bfacs_pkg::IRQ_W-1:0];
    end
  end

  // Read mux; unmapped and misaligned addresses read as zero
  always_comb begin
    rd_mux = bfacs_pkg::READ_ZERO;
    case (avs_address_i)
      bfacs_pkg::OFF_RESET_CONTROL: begin
        rd_mux[bfacs_pkg::ERR_BIT] = boot_config_error_flag_o;
        rd_mux[bfacs_pkg::FAIL_BIT] = boot_config_failure_flag_o;
        rd_mux[bfacs_pkg::DONE_BIT] = boot_done_o;
        rd_mux[bfacs_pkg::SWAP_BIT] = lower_bank_o;
      end
      bfacs_pkg::OFF_IRQ_STATUS: begin
        rd_mux[bfacs_pkg::IRQ_W-1:0] = irq_status;
      end
      bfacs_pkg::OFF_IRQ_MASK: begin
        rd_mux[bfacs_pkg::IRQ_W-1:0] = irq_mask;
      end
      bfacs_pkg::OFF_SEQ_TAGS: begin
        rd_mux = {tag2_q, tag1_q};
      end
      default: begin
        if (avs_address_i[1:0] == 2'h0 && avs_address_i >= bfacs_pkg::OFF_CFG_BASE
            && cfg_sel < 4'(bfacs_pkg::CFG_WORDS)) begin
          rd_mux = device_config_words_o[cfg_sel[bfacs_pkg::IDX_W-1:0]];
        end
      end
    endcase
  end

  // One wait cycle, then the access completes with waitrequest low
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if (ce_i) begin
      if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
        avs_waitrequest_o <= 1'b0;
      end else begin
        avs_waitrequest_o <= 1'b1;
      end
    end
  end

  // Read data captured in the wait cycle, held until the next read
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      avs_readdata_o <= bfacs_pkg::READ_ZERO;
    end else if (ce_i && avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= rd_mux;
    end
  end

  // Events: bit 0 primary ECC error, bit 1 ECC error in both copies, bit 2 done
  bfacs_irq_regs u_irq (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .ce_i(ce_i),
    .event_i({ev_done, ev_fail, ev_err}),
    .clear_i(irq_clear),
    .mask_wr_i(mask_wr),
    .mask_data_i(avs_writedata_i[bfacs_pkg::IRQ_W-1:0]),
    .status_o(irq_status),
    .mask_o(irq_mask),
    .irq_o(irq_o)
  );

endmodule

// ===== tb/bfacs_top_asserts.sv
// Checker for the boot alias loader: flash handshake, load order and flags.
// Bound to bfacs_top from the bench; one clock domain, ce_i held high.
`timescale 1ns/1ps
module bfacs_top_asserts (
  input wire logic sys_clk_i, // Clock
  input wire logic reset_n_i, // Reset, active low
  input wire bfacs_pkg::bfacs_req_s flash_req_o, // Flash request
  input wire bfacs_pkg::bfacs_rsp_s flash_rsp_i, // Flash answer
  input wire logic avs_read_i, // Bus read
  input wire logic avs_write_i, // Bus write
  input wire logic avs_waitrequest_o, // Bus wait
  input wire logic [bfacs_pkg::CFG_WORDS-1:0][bfacs_pkg::WORD_W-1:0] device_config_words_o, // Words
  input wire logic lower_bank_o, // Lower alias bank
  input wire logic boot_config_error_flag_o, // Error flag
  input wire logic boot_config_failure_flag_o, // Failure flag
  input wire logic boot_done_o // Start-up done
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!reset_n_i);
  logic took;
  logic prim_ue;
  logic cfg_take;
  assign took = flash_req_o.valid && flash_rsp_i.valid;
  assign prim_ue = took && flash_rsp_i.ue && !flash_req_o.alt;
  assign cfg_take = took && flash_req_o.space == bfacs_pkg::SPACE_CFG;
  a_req_holds: assert property (flash_req_o.valid && !flash_rsp_i.valid |=> $stable(flash_req_o))
    else $error("flash request changed before its answer");
  a_req_gap: assert property (took |=> !flash_req_o.valid)
    else $error("flash request not dropped after answer");
  a_done_quiet: assert property (boot_done_o |-> !flash_req_o.valid)
    else $error("flash request after start-up done");
  a_done_stable: assert property (boot_done_o |=> boot_done_o && $stable(device_config_words_o)
    && $stable(lower_bank_o) && $stable(boot_config_failure_flag_o))
    else $error("results moved after start-up done");
  a_cfg_lower: assert property (flash_req_o.valid && flash_req_o.space == bfacs_pkg::SPACE_CFG
    |-> flash_req_o.bank == lower_bank_o)
    else $error("configuration read from upper bank");
  a_alt_follows: assert property (prim_ue |=> ##1 flash_req_o.valid
    && flash_req_o[5:0] == ($past(flash_req_o[5:0], 2) | 6'h10))
    else $error("alternate word not read after ECC error");
  a_err_flag: assert property (prim_ue |=> boot_config_error_flag_o)
    else $error("error flag not set on primary ECC error");
  a_fail_default: assert property (cfg_take && flash_rsp_i.ue && flash_req_o.alt
    |=> boot_config_failure_flag_o && device_config_words_o[$past(flash_req_o.index)] == bfacs_pkg::CFG_DEFAULT)
    else $error("double ECC error not defaulted");
  a_cfg_load: assert property (cfg_take && !flash_rsp_i.ue
    |=> device_config_words_o[$past(flash_req_o.index)] == $past(flash_rsp_i.data))
    else $error("configuration word not loaded");
  a_fail_has_err: assert property (boot_config_failure_flag_o |-> boot_config_error_flag_o)
    else $error("failure flag without error flag");
  a_bus_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus access not answered after one wait cycle");
  c_done: cover property ($rose(boot_done_o));
  c_swap: cover property (boot_done_o && lower_bank_o);
  c_fail: cover property ($rose(boot_config_failure_flag_o));
  c_alt: cover property (took && flash_req_o.alt);
endmodule

// ===== tb/bfacs_flash_model.sv
// Behavioural model of the two boot flash banks with ECC status.
// The bench fills mem and bad while reset is held; lat_i sets answer delay.
`timescale 1ns/1ps
module bfacs_flash_model (
  input wire logic sys_clk_i, // Clock
  input wire logic reset_n_i, // Reset, active low
  input wire bfacs_pkg::bfacs_req_s req_i, // Read request
  input wire logic [1:0] lat_i, // Extra answer delay
  output bfacs_pkg::bfacs_rsp_s rsp_o // Read answer
);
  // Key is {bank, alt, space, index}: every word has its alternate
  // Contents are loaded whole, there is no single-word programming path
  logic [31:0] mem [64];
  logic bad [64];
  logic [1:0] wait_cnt;
  always_ff @(posedge sys_clk_i) begin
    if (!reset_n_i) begin
      wait_cnt <= 2'h0;
      rsp_o <= '0;
    end else if (req_i.valid && !rsp_o.valid && wait_cnt == lat_i) begin
      wait_cnt <= 2'h0;
      rsp_o <= {1'b1, bad[req_i[5:0]], mem[req_i[5:0]]};
    end else begin
      wait_cnt <= (req_i.valid && !rsp_o.valid) ? wait_cnt + 2'h1 : 2'h0;
      // Idle lines toggle so a stale word never passes for an answer
      rsp_o <= {1'b0, ~rsp_o.ue, ~rsp_o.data};
    end
  end
endmodule

// ===== tb/bfacs_top_bench.sv
// Self-checking bench: random boot images with corner cases, bus and irq checks.
// Needs bfacs_top, bfacs_flash_model and the checker.
`timescale 1ns/1ps
module bfacs_top_bench;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [5:0] avs_address_i = 6'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [1:0] lat = 2'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o, irq_o, lower_bank_o, boot_done_o;
  logic boot_config_error_flag_o, boot_config_failure_flag_o;
  logic [bfacs_pkg::CFG_WORDS-1:0][bfacs_pkg::WORD_W-1:0] device_config_words_o;
  bfacs_pkg::bfacs_req_s flash_req_o;
  bfacs_pkg::bfacs_rsp_s flash_rsp_i;
  logic [31:0] mem [64];
  logic bad [64];
  logic [15:0] lfsr = 16'h774D;
  int fails = 0;
  int tests_run = 0;
  always #25 sys_clk_i = ~sys_clk_i;
  bfacs_top dut (.sys_clk_i, .reset_n_i, .ce_i(1'b1), .flash_req_o, .flash_rsp_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'hF), .avs_readdata_o, .avs_waitrequest_o, .irq_o,
    .lower_bank_o, .device_config_words_o, .boot_config_error_flag_o, .boot_config_failure_flag_o, .boot_done_o);
  bfacs_flash_model flash (.sys_clk_i, .reset_n_i, .req_i(flash_req_o), .lat_i(lat), .rsp_o(flash_rsp_i));
  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction
  function automatic logic [15:0] tag_of(input logic [5:0] k);
    if (!bad[k] && mem[k][31:16] == ~mem[k][15:0]) begin
      return mem[k][15:0];
    end
    if (!bad[k | 6'h10] && mem[k | 6'h10][31:16] == ~mem[k | 6'h10][15:0]) begin
      return mem[k | 6'h10][15:0];
    end
    return 16'h0000;
  endfunction
  function automatic logic [31:0] cfg_of(input logic [5:0] k);
    if (!bad[k]) begin
      return mem[k];
    end
    return bad[k | 6'h10] ? bfacs_pkg::CFG_DEFAULT : mem[k | 6'h10];
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic av(input logic wr, input logic [5:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= wd;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    if (avs_waitrequest_o !== 1'b0) begin
      fails++;
      $display("[ERR] bus answer expected waitrequest 0 seen %b", avs_waitrequest_o);
    end
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic run(input int k);
    logic [15:0] t1, t2;
    logic [5:0] key;
    logic lo, err, fl;
    logic [31:0] w, rd;
    int n;
    reset_n_i <= 1'b0;
    for (int i = 0; i < 64; i++) begin
      w = {rnd(), rnd()};
      if (i[3] == 1'b0) w[31:16] = ~w[15:0];
      mem[i] = w;
      bad[i] = k == 4 || (k == 3 && !i[4]) || (k > 4 && (rnd() % 6) == 0);
    end
    if (k == 0) mem[32] = mem[0];
    if (k == 1) begin
      mem[0] = {16'h8000, 16'h7FFF};
      mem[32] = {16'h7FFF, 16'h8000};
    end
    if (k == 2) mem[0][31:16] = mem[0][15:0];
    // Both banks carry full configuration, whichever ends up lower
    for (int i = 0; i < 64; i++) begin
      flash.mem[i] = mem[i];
      flash.bad[i] = bad[i];
    end
    w = rnd();
    lat <= w[1:0];
    repeat (10) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    if (k == 5) begin
      repeat (7) @(posedge sys_clk_i);
      reset_n_i <= 1'b0;
      repeat (2) @(posedge sys_clk_i);
      reset_n_i <= 1'b1;
    end
    n = 0;
    while (boot_done_o !== 1'b1 && n < 400) begin
      @(posedge sys_clk_i);
      n++;
    end
    t1 = tag_of(6'h00);
    t2 = tag_of(6'h20);
    lo = t2 > t1;
    err = bad[0] | bad[32];
    fl = (bad[0] & bad[16]) | (bad[32] & bad[48]);
    check("done", {31'h0, boot_done_o}, 32'h1);
    check("lower bank", {31'h0, lower_bank_o}, {31'h0, lo});
    av(1'b0, bfacs_pkg::OFF_SEQ_TAGS, 32'h0, rd);
    check("tags", rd, {t2, t1});
    for (int i = 0; i < 6; i++) begin
      key = {lo, 2'b01, i[2:0]};
      err = err | bad[key];
      fl = fl | (bad[key] & bad[key | 6'h10]);
      check("cfg word", device_config_words_o[i], cfg_of(key));
      av(1'b0, bfacs_pkg::OFF_CFG_BASE + 6'(4 * i), 32'h0, rd);
      check("cfg reg", rd, cfg_of(key));
    end
    check("flags", {30'h0, boot_config_error_flag_o, boot_config_failure_flag_o}, {30'h0, err, fl});
    av(1'b1, bfacs_pkg::OFF_RESET_CONTROL, 32'hFFFFFFFF, rd);
    av(1'b0, bfacs_pkg::OFF_RESET_CONTROL, 32'h0, rd);
    check("reset control", rd, {4'h0, err, fl, 24'h0, 1'b1, lo});
    av(1'b0, 6'h3C, 32'h0, rd);
    check("unmapped", rd, 32'h00000000);
    check("irq masked", {31'h0, irq_o}, 32'h0);
    av(1'b1, bfacs_pkg::OFF_IRQ_MASK, 32'h00000007, rd);
    @(posedge sys_clk_i);
    check("irq raised", {31'h0, irq_o}, 32'h1);
    av(1'b0, bfacs_pkg::OFF_IRQ_STATUS, 32'h0, rd);
    check("irq status", rd, {29'h0, 1'b1, fl, err});
    @(posedge sys_clk_i);
    check("irq cleared", {31'h0, irq_o}, 32'h0);
    av(1'b0, bfacs_pkg::OFF_IRQ_MASK, 32'h0, rd);
    check("irq mask", rd, 32'h00000007);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    for (int k = 0; k < 12; k++) begin
      run(k);
      $display("run %0d ended, mismatches %0d", k, fails);
    end
    conclude();
  end
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    fails++;
    conclude();
  end
endmodule
bind bfacs_top bfacs_top_asserts chk (.sys_clk_i, .reset_n_i, .flash_req_o, .flash_rsp_i, .avs_read_i,
  .avs_write_i, .avs_waitrequest_o, .device_config_words_o, .lower_bank_o, .boot_config_error_flag_o,
  .boot_config_failure_flag_o, .boot_done_o);
